/* File: design/adc_compare_control.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`include "acc_defines.svh"

module adc_compare_control #(
    parameter int MC_DIV = `ACC_MC_CYC,
    parameter int CONV_MC = `ACC_CONV_MC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ACC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic compareIn,
    output logic [3:0] dacCode,
    output logic [2:0] chanSel,
    output logic convBusy,
    input wire logic [2:0] port3Out,
    input wire logic [2:0] port3PadIn,
    output logic [2:0] port3PadOut,
    output logic [2:0] port3PadOe,
    output logic [2:0] port3In
);
    import acc_pkg::*;

    acc_state_s st_ff;
    acc_state_s nxt_st;

    logic mcTick;
    logic setup;
    logic access;
    logic [1:0] selSetup;
    logic [1:0] selAccess;
    logic wrCtrl;
    logic wrPin;
    logic convDone;

    // bit 0 control register, bit 1 pin select register
    function automatic logic [1:0] regSel(input logic [`ACC_ADDR_W-1:0] a);
        regSel = {a == `ACC_PINSEL_ADDR, a == `ACC_CTRL_ADDR};
    endfunction : regSel

    // channel code to input one-hot, code 00 selects nothing
    function automatic logic [2:0] chanOneHot(input logic [1:0] c);
        unique case (c)
            2'h1: chanOneHot = 3'h1;
            2'h2: chanOneHot = 3'h2;
            2'h3: chanOneHot = 3'h4;
            2'h0: chanOneHot = 3'h0;
        endcase
    endfunction : chanOneHot

    acc_mc_tick #(
        .DIV(MC_DIV)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .restart(st_ff.launch),
        .tick(mcTick)
    );

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign selSetup = regSel(paddr);
    assign selAccess = regSel(paddr);
    assign wrCtrl = access && pwrite && selAccess[0];
    assign wrPin = access && pwrite && selAccess[1];
    assign convDone = (st_ff.phase == ACC_CONV) && mcTick && (st_ff.mcCnt == 4'(CONV_MC - 1));

    assign pready = access;
    assign pslverr = access && (selAccess == 2'h0);
    assign prdata = st_ff.rdata;
    assign dacCode = st_ff.refCode;
    assign chanSel = chanOneHot(st_ff.chan) & st_ff.pinEn;
    assign convBusy = (st_ff.phase == ACC_CONV);

    // open drain: only pulls low, released while the pin is analog
    assign port3PadOut = 3'h0;
    assign port3PadOe = ~st_ff.pinEn & ~port3Out;
    assign port3In = st_ff.portSync;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.cmpMeta = compareIn;
        nxt_st.cmpSync = st_ff.cmpMeta;
        nxt_st.portMeta = port3PadIn;
        nxt_st.portSync = st_ff.portMeta;
        // self-clearing launch strobe
        nxt_st.launch = 1'b0;

        // read data captured in setup, presented in access
        if (setup) begin
            if (selSetup[0]) begin
                nxt_st.rdata = {24'h0, st_ff.result, st_ff.chan, 1'b0, st_ff.refCode};
            end else if (selSetup[1]) begin
                nxt_st.rdata = {29'h0, st_ff.pinEn};
            end else begin
                nxt_st.rdata = 32'h0;
            end
        end

        if (wrCtrl) begin
            nxt_st.chan = pwdata[`ACC_CHAN_HI:`ACC_CHAN_LO];
            nxt_st.refCode = pwdata[`ACC_REF_HI:`ACC_REF_LO];
            nxt_st.launch = pwdata[`ACC_LAUNCH_BIT];
        end
        if (wrPin) begin
            nxt_st.pinEn = pwdata[`ACC_PINEN_HI:0];
        end

        unique case (st_ff.phase)
            ACC_IDLE: begin
                if (st_ff.launch && st_ff.chan != 2'h0) begin
                    nxt_st.phase = ACC_CONV;
                    nxt_st.mcCnt = 4'h0;
                end
            end
            ACC_CONV: begin
                if (st_ff.launch) begin
                    // relaunch restarts the count
                    nxt_st.mcCnt = 4'h0;
                    if (st_ff.chan == 2'h0) begin
                        nxt_st.phase = ACC_IDLE;
                    end
                end else if (convDone) begin
                    nxt_st.result = st_ff.cmpSync;
                    nxt_st.phase = ACC_IDLE;
                end else if (mcTick) begin
                    nxt_st.mcCnt = st_ff.mcCnt + 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // clocks since launch, for checking only
    logic [15:0] convAge_ff;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            convAge_ff <= 16'h0;
        end else if (st_ff.launch) begin
            convAge_ff <= 16'h1;
        end else if (st_ff.phase == ACC_CONV) begin
            convAge_ff <= convAge_ff + 16'h1;
        end
    end

    logic readCtrlDone;
    assign readCtrlDone = access && !pwrite && selAccess[0];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_one_input;
        $onehot0(chanSel) && ((chanSel & ~st_ff.pinEn) == 3'h0);
    endproperty
    a_one_input: assert property (p_one_input) else $error("more than one analog input selected");

    property p_result_from_comparator;
        convDone |=> st_ff.result == $past(st_ff.cmpSync);
    endproperty
    a_result_from_comparator: assert property (p_result_from_comparator)
        else $error("result does not follow comparator");

    property p_conv_time;
        convDone |-> (convAge_ff == 16'(CONV_MC * MC_DIV)) && !st_ff.launch;
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion length wrong");

    property p_launch_clears;
        st_ff.launch && !wrCtrl |=> !st_ff.launch;
    endproperty
    a_launch_clears: assert property (p_launch_clears) else $error("launch bit not cleared");

    property p_launch_reads_zero;
        readCtrlDone |-> prdata[`ACC_LAUNCH_BIT] == 1'b0;
    endproperty
    a_launch_reads_zero: assert property (p_launch_reads_zero) else $error("launch bit read as one");

    property p_result_read;
        readCtrlDone && $past(setup) |-> prdata[`ACC_RESULT_BIT] == $past(st_ff.result);
    endproperty
    a_result_read: assert property (p_result_read) else $error("result bit read wrong");

    property p_reserved_chan;
        st_ff.launch && st_ff.chan == 2'h0 |=> st_ff.phase == ACC_IDLE;
    endproperty
    a_reserved_chan: assert property (p_reserved_chan) else $error("reserved channel converted");

    property p_chan_decode;
        st_ff.pinEn == 3'h7 |-> chanSel == ((st_ff.chan == 2'h0) ? 3'h0 : (3'h1 << (st_ff.chan - 2'h1)));
    endproperty
    a_chan_decode: assert property (p_chan_decode) else $error("channel decode wrong");

    property p_launch_starts;
        wrCtrl && pwdata[`ACC_LAUNCH_BIT] && pwdata[`ACC_CHAN_HI:`ACC_CHAN_LO] != 2'h0
            |=> st_ff.launch ##1 convBusy [*2];
    endproperty
    a_launch_starts: assert property (p_launch_starts) else $error("launch did not start");

    property p_no_launch_idle;
        wrCtrl && !pwdata[`ACC_LAUNCH_BIT] && !convBusy && !st_ff.launch |=> ##1 !convBusy;
    endproperty
    a_no_launch_idle: assert property (p_no_launch_idle) else $error("conversion without launch");

    property p_dac_code;
        wrCtrl |=> dacCode == $past(pwdata[`ACC_REF_HI:`ACC_REF_LO]);
    endproperty
    a_dac_code: assert property (p_dac_code) else $error("reference code not applied");

    property p_pin_mode;
        wrPin |=> (st_ff.pinEn == $past(pwdata[`ACC_PINEN_HI:0])) && ((port3PadOe & st_ff.pinEn) == 3'h0);
    endproperty
    a_pin_mode: assert property (p_pin_mode) else $error("pin function wrong");

    property p_result_held;
        !convDone |=> $stable(st_ff.result);
    endproperty
    a_result_held: assert property (p_result_held) else $error("result changed outside completion");

    property p_ready_in_access;
        access |-> pready;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("no ready in access phase");

    property p_no_ready_idle;
        !access |-> !pready && !pslverr;
    endproperty
    a_no_ready_idle: assert property (p_no_ready_idle) else $error("ready or error outside access");

    property p_err_decode;
        access |-> pslverr == (selAccess == 2'h0);
    endproperty
    a_err_decode: assert property (p_err_decode) else $error("error response wrong");

    property p_read_upper_zero;
        access && !pwrite |-> prdata[31:8] == 24'h0;
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits not zero");

    property p_pinsel_read;
        access && !pwrite && selAccess[1] && $past(setup) |-> prdata == {29'h0, $past(st_ff.pinEn)};
    endproperty
    a_pinsel_read: assert property (p_pinsel_read) else $error("pin select read wrong");

    property p_unmapped_read_zero;
        access && !pwrite && selAccess == 2'h0 && $past(setup) |-> prdata == 32'h0;
    endproperty
    a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read not zero");

    property p_ctrl_fields;
        readCtrlDone && $past(setup) |-> prdata[`ACC_CHAN_HI:`ACC_CHAN_LO] == $past(st_ff.chan)
            && prdata[`ACC_REF_HI:`ACC_REF_LO] == $past(st_ff.refCode);
    endproperty
    a_ctrl_fields: assert property (p_ctrl_fields) else $error("control fields read wrong");

    property p_chan_write;
        wrCtrl |=> st_ff.chan == $past(pwdata[`ACC_CHAN_HI:`ACC_CHAN_LO]);
    endproperty
    a_chan_write: assert property (p_chan_write) else $error("channel not written");

    property p_launch_write;
        wrCtrl |=> st_ff.launch == $past(pwdata[`ACC_LAUNCH_BIT]);
    endproperty
    a_launch_write: assert property (p_launch_write) else $error("launch strobe not written");

    property p_unmapped_write;
        access && pwrite && selAccess == 2'h0 |=> $stable(st_ff.chan) && $stable(st_ff.refCode)
            && $stable(st_ff.pinEn);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write changed state");

    property p_pin_hold;
        !wrPin |=> $stable(st_ff.pinEn);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("pin select changed without write");

    property p_dac_hold;
        !wrCtrl |=> $stable(dacCode);
    endproperty
    a_dac_hold: assert property (p_dac_hold) else $error("reference changed without write");

    property p_busy_ends;
        convDone |=> !convBusy;
    endproperty
    a_busy_ends: assert property (p_busy_ends) else $error("busy after completion");

    property p_busy_holds;
        convBusy && !convDone && !st_ff.launch |=> convBusy;
    endproperty
    a_busy_holds: assert property (p_busy_holds) else $error("conversion ended early");

    property p_tick_spacing;
        mcTick |=> !mcTick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("machine cycle ticks too close");

    property p_count_bounded;
        convBusy |-> st_ff.mcCnt < 4'(CONV_MC);
    endproperty
    a_count_bounded: assert property (p_count_bounded) else $error("cycle count overran");

    property p_relaunch;
        convBusy && st_ff.launch && st_ff.chan != 2'h0 |=> convBusy && st_ff.mcCnt == 4'h0;
    endproperty
    a_relaunch: assert property (p_relaunch) else $error("relaunch did not restart");

    property p_cmp_sync;
        st_ff.cmpSync == $past(st_ff.cmpMeta);
    endproperty
    a_cmp_sync: assert property (p_cmp_sync) else $error("comparator sync stage wrong");

    property p_port_sync;
        port3In == $past(st_ff.portMeta);
    endproperty
    a_port_sync: assert property (p_port_sync) else $error("port input sync wrong");

    property p_idle_stays;
        !convBusy && !st_ff.launch |=> !convBusy;
    endproperty
    a_idle_stays: assert property (p_idle_stays) else $error("conversion started unasked");

    property p_launch_from_write;
        st_ff.launch |-> $past(wrCtrl);
    endproperty
    a_launch_from_write: assert property (p_launch_from_write) else $error("launch without write");

    c_conv_done: cover property (convDone);
    c_relaunch: cover property (convBusy && st_ff.launch);
    c_reserved: cover property (st_ff.launch && st_ff.chan == 2'h0);
    c_pin_write: cover property (wrPin && pwdata[2:0] == 3'h7);

endmodule : adc_compare_control

/* File: design/acc_defines.svh */
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// register indices; byte address is four times the index
`define ACC_CTRL_IDX 8'hC8
`define ACC_PINSEL_IDX 8'hCA
`define ACC_ADDR_W 12
`define ACC_CTRL_ADDR {2'h0, `ACC_CTRL_IDX, 2'h0}
`define ACC_PINSEL_ADDR {2'h0, `ACC_PINSEL_IDX, 2'h0}

// control and pin select register fields
`define ACC_RESULT_BIT 7
`define ACC_CHAN_HI 6
`define ACC_CHAN_LO 5
`define ACC_LAUNCH_BIT 4
`define ACC_REF_HI 3
`define ACC_REF_LO 0
`define ACC_PINEN_HI 2

// reset values
`define ACC_CHAN_RST 2'h0
`define ACC_REF_RST 4'h0
`define ACC_PINEN_RST 3'h0

// timing
`define ACC_CLK_NS 25
`define ACC_MC_NS 1000
`define ACC_MC_CYC ((`ACC_MC_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_CONV_MC 8

`endif

/* File: design/acc_pkg.sv */
package acc_pkg;

    typedef enum logic {
        ACC_IDLE,
        ACC_CONV
    } acc_phase_e;

    typedef struct packed {
        acc_phase_e phase;
        logic [1:0] chan;
        logic [3:0] refCode;
        logic result;
        logic launch;
        logic [2:0] pinEn;
        logic [3:0] mcCnt;
        logic cmpMeta;
        logic cmpSync;
        logic [2:0] portMeta;
        logic [2:0] portSync;
        logic [31:0] rdata;
    } acc_state_s;

endpackage : acc_pkg

/* File: design/acc_mc_tick.sv */
`timescale 1ns/1ps
`include "acc_defines.svh"

// machine-cycle enable, realigned by restart
module acc_mc_tick #(
    parameter int DIV = `ACC_MC_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic restart,
    output logic tick
);
    import acc_pkg::*;

    localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;

    typedef struct packed {
        logic [CW-1:0] cnt;
    } acc_tick_s;

    acc_tick_s st_ff;
    acc_tick_s nxt_st;

    assign tick = (st_ff.cnt == CW'(DIV - 1)) && !restart;

    always_comb begin
        nxt_st = st_ff;
        if (restart || st_ff.cnt == CW'(DIV - 1)) begin
            nxt_st.cnt = '0;
        end else begin
            nxt_st.cnt = st_ff.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

endmodule : acc_mc_tick

/* File: dv/acc_analog_src.sv */
`timescale 1ns/1ps
module acc_analog_src (
    input wire logic clk,
    input wire logic [2:0] chanSel,
    input wire logic [3:0] dacCode,
    input wire logic [2:0] port3PadOe,
    input wire logic [14:0] vin,
    output logic compareIn,
    output logic [2:0] port3PadIn
);
    logic wander = 1'b0;
    logic [5:0] lvl;
    always @(posedge clk) wander <= ~wander;
    // levels in 1/32 of supply, reference is (code+1)/16
    always_comb begin
        lvl = 6'h0;
        if (chanSel[0]) lvl = {1'b0, vin[4:0]};
        if (chanSel[1]) lvl = {1'b0, vin[9:5]};
        if (chanSel[2]) lvl = {1'b0, vin[14:10]};
    end
    // nothing connected: comparator output is meaningless
    assign compareIn = (chanSel == 3'h0) ? wander : (lvl > {dacCode + 5'h1, 1'b0});
    // open-drain line with pull-up
    assign port3PadIn = ~port3PadOe;
endmodule : acc_analog_src

/* File: dv/adc_compare_control_bench.sv */
`timescale 1ns/1ps
`include "acc_defines.svh"
module adc_compare_control_bench;
    localparam int MCD = 4;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, compareIn, convBusy, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] dacCode;
    logic [2:0] chanSel, port3Out, port3PadIn, port3PadOut, port3PadOe, port3In;
    logic [14:0] vin;
    int errTotal, nCompared, ch, rf, pe, res, nxt;
    int expQ[$];
    adc_compare_control #(.MC_DIV(MCD), .CONV_MC(8)) adc_compare_control_i (.clk(clk), .nrst(nrst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .compareIn(compareIn), .dacCode(dacCode), .chanSel(chanSel),
        .convBusy(convBusy), .port3Out(port3Out), .port3PadIn(port3PadIn), .port3PadOut(port3PadOut),
        .port3PadOe(port3PadOe), .port3In(port3In));
    acc_analog_src acc_analog_src_i (.clk(clk), .chanSel(chanSel), .dacCode(dacCode),
        .port3PadOe(port3PadOe), .vin(vin), .compareIn(compareIn), .port3PadIn(port3PadIn));
    always #12.5 clk = ~clk;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            errTotal++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) errTotal++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [31:0] ctrlVal();
        return {24'h0, res[0], ch[1:0], 1'b0, rf[3:0]};
    endfunction : ctrlVal
    function automatic logic [31:0] selExp();
        return (ch == 0) ? 32'h0 : (32'h1 << (ch - 1)) & pe;
    endfunction : selExp
    task conv(input int c, input int r, input logic go);
        apb(1'b1, `ACC_CTRL_ADDR, {25'h0, c[1:0], go, r[3:0]} | ($urandom & 32'h80));
        ch = c;
        rf = r;
        nxt = ((vin >> (5 * c - 5)) % 32) > (2 * r + 2);
        if (go && c != 0) expQ.push_back(nxt);
        apb(1'b0, `ACC_CTRL_ADDR, 32'h0);
        chk("ctrl", rd, ctrlVal());
        chk("dac", dacCode, rf);
        chk("sel", chanSel, selExp());
        chk("busy", convBusy, go && c != 0);
        repeat (8 * MCD - 6) @(posedge clk);
        apb(1'b0, `ACC_CTRL_ADDR, 32'h0);
        chk("early", rd, ctrlVal());
        repeat (8) @(posedge clk);
        if (expQ.size() > 0) res = expQ.pop_front();
        apb(1'b0, `ACC_CTRL_ADDR, 32'h0);
        chk("result", rd, ctrlVal());
        chk("idle", convBusy, 0);
    endtask : conv
    task conclude();
        $display("compared %0d mismatches %0d", nCompared, errTotal);
        if (errTotal == 0 && nCompared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (6000) @(posedge clk);
        errTotal++;
        conclude();
    end
    initial begin
        {clk, nrst, psel, penable, pwrite, paddr, pwdata, port3Out, vin} = '0;
        {errTotal, nCompared, ch, rf, pe, res} = '0;
        void'($urandom(76490));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, `ACC_CTRL_ADDR, 32'h0);
        chk("ctrl_rst", rd, 32'h0);
        apb(1'b0, `ACC_PINSEL_ADDR, 32'h0);
        chk("pinsel_rst", rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            pe = $urandom % 8;
            port3Out <= 3'($urandom);
            apb(1'b1, `ACC_PINSEL_ADDR, 32'hFFFFFFF8 | pe);
            apb(1'b0, `ACC_PINSEL_ADDR, 32'h0);
            chk("pinsel", rd, pe);
            chk("oe", port3PadOe, 3'(~pe[2:0] & ~port3Out));
            chk("padout", port3PadOut, 0);
            chk("portin", port3In, 3'(pe[2:0] | port3Out));
        end
        $display("test pin select done");
        pe = 7;
        apb(1'b1, `ACC_PINSEL_ADDR, 32'h7);
        for (int i = 0; i < 12; i++) begin
            vin <= 15'($urandom) | 15'h0421;
            conv(1 + i % 3, $urandom % 16, 1'b1);
        end
        conv(0, $urandom % 16, 1'b1);
        conv(2, $urandom % 16, 1'b0);
        pe = 1;
        apb(1'b1, `ACC_PINSEL_ADDR, 32'h1);
        @(posedge clk);
        chk("sel_gate", chanSel, selExp());
        $display("test conversions done");
        apb(1'b1, 12'h324, 32'hFF);
        chk("err_wr", er, 1);
        apb(1'b0, 12'h324, 32'h0);
        chk("err_rd", er, 1);
        chk("err_rd_data", rd, 0);
        apb(1'b0, `ACC_CTRL_ADDR, 32'h0);
        chk("err_ok", er, 0);
        chk("ctrl_kept", rd, ctrlVal());
        $display("test unmapped done");
        conclude();
    end
endmodule : adc_compare_control_bench
